// ==== verilog/parallel_host_receive_port.sv ====
// Parallel host receive port with AXI4-Lite register access
// Function
// - Host strobe low starts a transfer; data captured at strobe rising edge.
// - Eight data lines carry bits one to eight, high means one.
// - Busy and acknowledge together pace the host, one byte at a time.
// - Acknowledge driven low signals the byte was stored; the next byte is accepted once it returns high.
// - Busy stays high whenever another byte cannot be accepted.
// - Media-empty output high when paper is out, low otherwise.
// - Unit-online output always high, host sees printer selected.
// - Fault output low during error, high otherwise.
`timescale 1ns/1ps
module parallel_host_receive_port
  import parport_pkg::*;
#(
  parameter int ack_len = parport_pkg::ack_cycles
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        host_strobe_n,
  input  wire logic [7:0]  host_data,
  output logic             ack_n,
  output logic             busy,
  output logic             media_empty,
  output logic             unit_online,
  output logic             fault_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  import parport_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [8:0] pins_sync;
  logic       strobe_s;
  logic [7:0] data_s;
  logic       strobe_d_reg;
  logic       strobe_d_next;
  logic       strobe_rise;

  strobe_sync #(.width(9)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({host_strobe_n, host_data}),
    .sync_out (pins_sync)
  );

  assign strobe_s      = pins_sync[8];
  assign data_s        = pins_sync[7:0];
  assign strobe_d_next = strobe_s;
  assign strobe_rise   = strobe_s && !strobe_d_reg;

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  hs_state_t   state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] low_cnt_reg, low_cnt_next;
  logic [7:0]  byte_reg, byte_next;
  logic [7:0]  hold_reg, hold_next;
  logic        full_reg, full_next;
  logic        data_rd;
  logic        byte_ev;
  logic        overrun_ev;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    byte_next  = byte_reg;
    hold_next  = hold_reg;
    full_next  = full_reg;
    byte_ev    = 1'b0;
    overrun_ev = 1'b0;
    low_cnt_next = ack_n ? 16'h0000 : low_cnt_reg + 16'h0001;
    if (data_rd)
      full_next = 1'b0;
    case (state_reg)
      hs_idle:
      begin
        if (strobe_rise)
        begin
          hold_next  = data_s;
          state_next = hs_hold;
        end
      end
      hs_hold: state_next = hs_wait;
      hs_wait:
      begin
        if (!full_reg || data_rd)
        begin
          byte_next  = hold_reg;
          full_next  = 1'b1;
          byte_ev    = 1'b1;
          cnt_next   = 16'(ack_len);
          state_next = hs_ack;
        end
      end
      hs_ack:
      begin
        if (cnt_reg == 16'h0001)
          state_next = hs_idle;
        else
          cnt_next = cnt_reg - 16'h0001;
        if (strobe_rise)
          overrun_ev = 1'b1;
      end
      default: state_next = hs_idle;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= hs_idle;
      cnt_reg      <= 16'h0000;
      byte_reg     <= 8'h00;
      hold_reg     <= 8'h00;
      full_reg     <= 1'b0;
      strobe_d_reg <= 1'b1;
      low_cnt_reg  <= 16'h0000;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      byte_reg     <= byte_next;
      hold_reg     <= hold_next;
      full_reg     <= full_next;
      strobe_d_reg <= strobe_d_next;
      low_cnt_reg  <= low_cnt_next;
    end
  end

  assign busy  = (state_reg != hs_idle);
  assign ack_n = !(state_reg == hs_ack);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0]          ctrl_reg, ctrl_next;
  logic [irq_width-1:0] irq_reg, irq_next;
  logic [irq_width-1:0] mask_reg, mask_next;
  logic                 aw_got_reg, aw_got_next;
  logic                 w_got_reg, w_got_next;
  logic [7:0]           awaddr_reg, awaddr_next;
  logic [31:0]          wdata_reg, wdata_next;
  logic [3:0]           wstrb_reg, wstrb_next;
  logic                 bvalid_reg, bvalid_next;
  logic [1:0]           bresp_reg, bresp_next;
  logic                 rvalid_reg, rvalid_next;
  logic [1:0]           rresp_reg, rresp_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic                 do_write;
  logic                 do_read;
  logic [31:0]          wmerged;
  logic                 irq_rd;
  logic [irq_width-1:0] irq_set;

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_write      = aw_got_reg && w_got_reg && !bvalid_reg;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign data_rd       = do_read && (s_axi_araddr == data_off);
  assign irq_rd        = do_read && (s_axi_araddr == irq_off);
  assign irq_set       = {overrun_ev, byte_ev};

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmerged[i*8 +: 8] = wstrb_reg[i] ? wdata_reg[i*8 +: 8] : ctrl_reg[i*8 +: 8];
  end

  always_comb
  begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    ctrl_next   = ctrl_reg;
    mask_next   = mask_reg;
    irq_next    = irq_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = resp_okay;
      if (awaddr_reg == ctrl_off)
        ctrl_next = wmerged;
      else if (awaddr_reg == mask_off)
      begin
        if (wstrb_reg[0])
          mask_next = wdata_reg[irq_width-1:0];
      end
      else if (awaddr_reg != status_off && awaddr_reg != data_off && awaddr_reg != irq_off)
        bresp_next = resp_slverr;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    if (do_read)
    begin
      rvalid_next = 1'b1;
      rresp_next  = resp_okay;
      rdata_next  = 32'h0000_0000;
      case (s_axi_araddr)
        ctrl_off:   rdata_next = ctrl_reg;
        status_off:
        begin
          rdata_next[stat_full_bit]   = full_reg;
          rdata_next[stat_busy_bit]   = busy;
          rdata_next[stat_strobe_bit] = strobe_s;
        end
        data_off:   rdata_next[7:0] = byte_reg;
        irq_off:    rdata_next[irq_width-1:0] = irq_reg;
        mask_off:   rdata_next[irq_width-1:0] = mask_reg;
        default:    rresp_next = resp_slverr;
      endcase
    end
    // Set wins over read clear
    if (irq_rd)
      irq_next = irq_set;
    else
      irq_next = irq_reg | irq_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= resp_okay;
      rvalid_reg <= 1'b0;
      rresp_reg  <= resp_okay;
      rdata_reg  <= 32'h0000_0000;
      ctrl_reg   <= ctrl_reset;
      mask_reg   <= mask_reset[irq_width-1:0];
      irq_reg    <= '0;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      ctrl_reg   <= ctrl_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;
  assign irq          = |(irq_reg & mask_reg);

  // ------------------------------------------------------------
  // Status pins
  // ------------------------------------------------------------
  assign media_empty = ctrl_reg[ctrl_media_empty_bit];
  assign fault_n     = !ctrl_reg[ctrl_fault_bit];
  assign unit_online = 1'b1;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_rise_to_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    (!busy && strobe_rise) |=> busy) else $error("busy not raised after strobe edge");
  a_byte_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (!busy && strobe_rise) |=> (hold_reg == $past(data_s))) else $error("byte not captured");
  a_ack_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    !ack_n |-> busy) else $error("ack low without busy");
  a_ack_width: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ack_n) |-> low_cnt_reg == 16'(ack_len)) else $error("ack pulse width wrong");
  a_busy_release: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ack_n) |-> !busy) else $error("busy not released with ack end");
  a_stored_full: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(ack_n) |-> full_reg && byte_reg == $past(hold_reg)) else $error("byte not stored");
  a_media_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    media_empty == ctrl_reg[ctrl_media_empty_bit]) else $error("media empty pin mismatch");
  a_fault_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_n != ctrl_reg[ctrl_fault_bit]) else $error("fault pin mismatch");
  a_online_high: assert property (@(posedge aclk) disable iff (!aresetn)
    unit_online) else $error("online pin low");
endmodule

// ==== verilog/parport_pkg.sv ====
// Package: constants for the parallel host receive port
package parport_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] data_off   = 8'h08;
  localparam logic [7:0] irq_off    = 8'h0c;
  localparam logic [7:0] mask_off   = 8'h10;
  // Control fields
  localparam int ctrl_media_empty_bit = 0;
  localparam int ctrl_fault_bit       = 1;
  // Status fields
  localparam int stat_full_bit   = 0;
  localparam int stat_busy_bit   = 1;
  localparam int stat_strobe_bit = 2;
  // Interrupt fields
  localparam int irq_byte_bit    = 0;
  localparam int irq_overrun_bit = 1;
  localparam int irq_width       = 2;
  // Reset values
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] mask_reset = 32'h0000_0000;
  // Timing: acknowledge pulse width
  localparam int clk_mhz       = 25;
  localparam int ack_width_ns  = 1000;
  localparam int ack_cycles    = (ack_width_ns * clk_mhz + 999) / 1000;
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  typedef enum logic [1:0] {hs_idle, hs_hold, hs_wait, hs_ack} hs_state_t;
endpackage

// ==== verilog/strobe_sync.sv ====
// Two-stage synchroniser for the host pins
`timescale 1ns/1ps
module strobe_sync #(
  parameter int width = 9
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);
  logic [width-1:0] stage1_reg;
  logic [width-1:0] stage2_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule

// ==== sim/host_port_model.sv ====
// Behavioural host computer driving the parallel receive port
`timescale 1ns/1ps
module host_port_model (
  input  wire logic       aclk,
  input  wire logic       busy,
  input  wire logic       ack_n,
  output logic            host_strobe_n,
  output logic      [7:0] host_data
);
  initial
  begin
    host_strobe_n = 1'b1;
    host_data     = 8'h00;
  end

  // ----------------------------------------
  // One byte transfer, strobe held low for hold cycles
  // ----------------------------------------
  task automatic send(input logic [7:0] b, input int hold);
    while (busy !== 1'b0 || ack_n !== 1'b1) @(posedge aclk);
    host_data <= b;
    @(posedge aclk);
    host_strobe_n <= 1'b0;
    repeat (hold) @(posedge aclk);
    host_strobe_n <= 1'b1;
    @(posedge aclk);
    while (busy !== 1'b1) @(posedge aclk);
    host_data <= ~b;
    while (ack_n !== 1'b0) @(posedge aclk);
    while (ack_n !== 1'b1) @(posedge aclk);
  endtask

  // ----------------------------------------
  // Bare strobe pulse that ignores the handshake
  // ----------------------------------------
  task automatic pulse(input int hold);
    host_strobe_n <= 1'b0;
    repeat (hold) @(posedge aclk);
    host_strobe_n <= 1'b1;
    @(posedge aclk);
  endtask
endmodule

// ==== sim/parallel_host_receive_port_tb_top.sv ====
// Self-checking bench for the parallel host receive port
`timescale 1ns/1ps
module parallel_host_receive_port_tb_top;
  import parport_pkg::*;
  localparam int ack_test = 6;
  logic aclk, aresetn, host_strobe_n, ack_n, busy, media_empty, unit_online, fault_n, irq;
  logic [7:0] host_data, s_axi_awaddr, s_axi_araddr, b1, b2;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] q[$];
  int errors, num_checks, acnt, seed;

  parallel_host_receive_port #(.ack_len(ack_test)) parallel_host_receive_port_inst (
    .aclk, .aresetn, .host_strobe_n, .host_data, .ack_n, .busy, .media_empty,
    .unit_online, .fault_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
  );
  host_port_model host_port_model_inst (.aclk, .busy, .ack_n, .host_strobe_n, .host_data);

  // ----------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, bd;
    aw = 1;
    w = 1;
    bd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
      bd = (s_axi_bvalid === 1'b1);
    end
    chk(s_axi_bresp, resp_okay, "write response");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, rdn;
    ar = 1;
    rdn = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rdn)
    begin
      @(posedge aclk);
      if (ar && s_axi_arready === 1'b1)
      begin
        ar = 0;
        s_axi_arvalid <= 1'b0;
      end
      rdn = (s_axi_rvalid === 1'b1);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // ----------------------------------------
  // Clock, watchdog and acknowledge monitor
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial
  begin
    #800000;
    errors++;
    conclude();
  end

  always @(posedge aclk)
  begin
    if (aresetn === 1'b1 && ack_n === 1'b0)
    begin
      acnt++;
      chk(busy, 1'b1, "busy during ack");
    end
    else if (acnt != 0)
    begin
      chk(acnt, ack_test, "ack width");
      acnt = 0;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    seed = 94908;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({ack_n, busy, irq}, 3'b100, "reset handshake");
    chk({media_empty, unit_online, fault_n}, 3'b011, "reset status");
    axi_rd(ctrl_off, rd, rr);
    chk(rd, ctrl_reset, "ctrl reset");
    axi_rd(mask_off, rd, rr);
    chk(rd, mask_reset, "mask reset");
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(ctrl_off, i);
      @(posedge aclk);
      chk(media_empty, i[0], "media empty");
      chk(fault_n, !i[1], "fault");
      axi_rd(ctrl_off, rd, rr);
      chk(rd, i, "ctrl readback");
      chk(rr, resp_okay, "read response");
    end
    axi_wr(mask_off, 32'h0000_0001);
    for (int i = 0; i < 3; i++)
    begin
      b1 = $random(seed);
      q.push_back(b1);
      host_port_model_inst.send(b1, 1 + ($random(seed) & 3));
      chk(irq, 1'b1, "irq raised");
      axi_rd(irq_off, rd, rr);
      chk(rd, 32'h0000_0001, "irq status");
      @(posedge aclk);
      chk(irq, 1'b0, "irq cleared");
      axi_rd(data_off, rd, rr);
      chk(rd, 32'(q.pop_front()), "data byte");
    end
    axi_wr(mask_off, 32'h0000_0000);
    b1 = $random(seed);
    b2 = $random(seed);
    host_port_model_inst.send(b1, 2);
    axi_rd(status_off, rd, rr);
    chk(rd[stat_full_bit], 1'b1, "data full");
    fork
      host_port_model_inst.send(b2, 3);
      begin
        repeat (30) @(posedge aclk);
        chk({busy, ack_n}, 2'b11, "busy while full");
        axi_rd(data_off, rd, rr);
        chk(rd, 32'(b1), "first byte");
      end
    join
    axi_rd(data_off, rd, rr);
    chk(rd, 32'(b2), "second byte");
    chk(irq, 1'b0, "masked irq");
    axi_rd(irq_off, rd, rr);
    chk(rd, 32'h0000_0001, "masked status");
    b1 = $random(seed);
    fork
      host_port_model_inst.send(b1, 1);
      begin
        while (ack_n !== 1'b0) @(posedge aclk);
        host_port_model_inst.pulse(1);
      end
    join
    axi_rd(irq_off, rd, rr);
    chk(rd, 32'h0000_0003, "overrun status");
    axi_rd(data_off, rd, rr);
    chk(rd, 32'(b1), "byte kept on overrun");
    axi_rd(status_off, rd, rr);
    chk(rd, 32'h0000_0004, "idle status");
    axi_rd(8'h20, rd, rr);
    chk(rr, resp_slverr, "unmapped response");
    chk(rd, 32'h0000_0000, "unmapped data");
    chk(unit_online, 1'b1, "online");
    conclude();
  end
endmodule
